// [hw/dpt_pkg.sv]
// Package for the dual-port RAM test logic: field positions, sizes, carriers.
// Assumes a single core clock and synchronous internal I/O bus accesses.
package dpt_pkg;
	// ==========================================================
	// Field positions
	localparam int DPT_PTR_BITS = 6; // Pointer width
	localparam int DPT_WRAP_POS = 6; // Wrap bit in pointer read
	localparam int DPT_FLAG_POS = 7; // Status bit in pointer read
	localparam int DPT_CTL_QUAD_POS = 0; // Quad-write bit in control
	localparam int DPT_CTL_STRESS_POS = 1; // Stress bit in control
	localparam int DPT_CTL_TEST_POS = 2; // Test-mode bit in control
	// ==========================================================
	// Reset values
	localparam logic [7:0] DPT_CTL_RESET = 8'h00; // Control reset
	localparam logic [6:0] DPT_PTR_RESET = 7'h00; // Pointer reset
	// ==========================================================
	// Timing (tester side, informative)
	localparam int DPT_STRESS_NS = 500; // Least stress hold
	localparam int DPT_CLK_NS = 8; // Clock period
	localparam int DPT_STRESS_CYC = (DPT_STRESS_NS + DPT_CLK_NS - 1) / DPT_CLK_NS;
	// ==========================================================
	// Destination bus write carrier
	typedef struct packed {
		logic wen_n; // Destination write strobe, active low
		logic [7:0] addr; // Destination address
		logic [7:0] data; // Destination data
	} dpt_dest_s;
endpackage

// [hw/dpt_ram_cell.sv]
// Byte-wide dual-port RAM cell with stress-lock.
// Assumes destination writes last one cycle and the stress bit is a level.
`timescale 1ns/100ps
`default_nettype none
module dpt_ram_cell #(
	parameter int AW = 6
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sel, // Destination bus selects this cell
	input wire dpt_pkg::dpt_dest_s dest, // Destination bus write
	input wire logic stress_bit, // Stress mode enable
	input wire logic [AW-1:0] rd_addr, // Source side address
	output logic [7:0] rd_data, // Source side data
	output logic locked, // Lock state
	output logic test_in // RAM cell test input
);
	// ==========================================================
	// Storage
	logic [7:0] mem [0:(1<<AW)-1]; // Byte store
	logic [7:0] lock_data_reg; // Latched data
	logic [AW-1:0] lock_addr_reg; // Latched address
	logic locked_reg; // Lock state
	logic dest_wr; // Write from destination bus

	assign dest_wr = sel && !dest.wen_n && !locked_reg;

	// Lock entry and release
	always_ff @(posedge core_clk) begin
		if (rst || !stress_bit) begin
			locked_reg <= 1'b0;
		end else if (dest_wr) begin
			locked_reg <= 1'b1;
		end
	end

	// Latch data and address on lock entry
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lock_data_reg <= 8'h00;
			lock_addr_reg <= '0;
		end else if (dest_wr && stress_bit) begin
			lock_data_reg <= dest.data;
			lock_addr_reg <= dest.addr[AW-1:0];
		end
	end

	// Normal write, or the stretched write held while locked; the latched
	// byte equals the preload, since a sound cell resists the complement
	always_ff @(posedge core_clk) begin
		if (dest_wr) begin
			mem[dest.addr[AW-1:0]] <= dest.data;
		end else if (locked_reg) begin
			mem[lock_addr_reg] <= lock_data_reg;
		end
	end

	// Source side keeps working in every state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

	assign locked = locked_reg;
	assign test_in = locked_reg;
endmodule
`default_nettype wire

// [hw/dpt_test_top.sv]
// Dual-port RAM test logic: FIFO quad-write, pointer reads, stress locks.
// Assumes internal I/O bus accesses are one-cycle strobes on core_clk.
`timescale 1ns/100ps
`default_nettype none
module dpt_test_top #(
	parameter int AW = 6
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ctl_wr, // Write to chip_test_control_reg
	input wire logic data_wr, // Write to fifo_data_port
	input wire logic wptr_wr, // Write to fifo_write_pointer
	input wire logic rptr_wr, // Write to fifo_read_pointer
	input wire logic data_rd, // Read of fifo_data_port
	input wire logic wptr_rd, // Read of fifo_write_pointer
	input wire logic rptr_rd, // Read of fifo_read_pointer
	input wire logic scratch_wr, // Write to scratch RAM
	input wire logic scratch_rd, // Read of scratch RAM
	input wire logic scb_wr, // Write to control-block RAM
	input wire logic scb_rd, // Read of control-block RAM
	input wire dpt_pkg::dpt_dest_s dest_bus, // Destination data/address/strobe
	input wire logic fifo_data_holding_flag, // FIFO status from data path
	output logic [7:0] source_read_bus, // Source data bus
	output logic quad_write_test_bit, // Quad mode
	output logic ram_stress_bit, // Stress mode
	output logic [2:0] stress_lock_state, // Locks: fifo, scratch, scb
	output logic [2:0] ram_test_in // Cell test inputs
);
	// ==========================================================
	// Control and pointers
	logic [7:0] ctl_reg; // chip_test_control_reg
	logic [6:0] wptr_reg; // Write pointer with wrap bit
	logic [6:0] rptr_reg; // Read pointer with wrap bit
	logic test_mode; // Test mode bit
	logic [1:0] rd_src_reg; // Source mux select
	logic rd_pend_reg; // A RAM read was taken last cycle
	logic [1:0] lane_reg; // FIFO lane of that read
	logic [7:0] q_rd [0:3]; // FIFO lane read data
	logic [7:0] s_rd; // Scratch read data
	logic [7:0] c_rd; // Control-block read data
	logic [3:0] q_lock; // FIFO lane locks
	logic [3:0] q_tst; // FIFO lane test inputs
	logic [3:0] q_sel; // FIFO lane selects
	dpt_pkg::dpt_dest_s fifo_dest; // FIFO lane write bus

	assign test_mode = ctl_reg[dpt_pkg::DPT_CTL_TEST_POS];
	assign quad_write_test_bit = ctl_reg[dpt_pkg::DPT_CTL_QUAD_POS];
	assign ram_stress_bit = ctl_reg[dpt_pkg::DPT_CTL_STRESS_POS];

	// Control register write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctl_reg <= dpt_pkg::DPT_CTL_RESET;
		end else if (ctl_wr) begin
			ctl_reg <= dest_bus.data;
		end
	end

	// Write pointer: loads, or advances after each data write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wptr_reg <= dpt_pkg::DPT_PTR_RESET;
		end else if (wptr_wr) begin
			wptr_reg <= {1'b0, dest_bus.data[5:0]};
		end else if (data_wr) begin
			wptr_reg <= wptr_reg + 7'h01;
		end
	end

	// Read pointer: loaded by software, or advances after each data read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rptr_reg <= dpt_pkg::DPT_PTR_RESET;
		end else if (rptr_wr) begin
			rptr_reg <= {1'b0, dest_bus.data[5:0]};
		end else if (data_rd) begin
			rptr_reg <= rptr_reg + 7'h01;
		end
	end

	// FIFO four lanes; quad mode selects all four
	always_comb begin
		fifo_dest = dest_bus;
		fifo_dest.addr = {2'b00, wptr_reg[5:0]};
		q_sel = quad_write_test_bit ? 4'hF : 4'h1;
		if (!data_wr) begin
			q_sel = 4'h0;
		end
	end

	// One cell per FIFO lane, each with its own lock
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : lane
			dpt_ram_cell #(.AW(AW)) u_cell (
				.core_clk(core_clk),
				.rst(rst),
				.sel(q_sel[g]),
				.dest(fifo_dest),
				.stress_bit(ram_stress_bit),
				.rd_addr(rptr_reg[AW-1:0]),
				.rd_data(q_rd[g]),
				.locked(q_lock[g]),
				.test_in(q_tst[g])
			);
		end
	endgenerate

	// Scratch RAM with lock
	dpt_ram_cell #(.AW(AW)) u_scratch (
		.core_clk(core_clk),
		.rst(rst),
		.sel(scratch_wr),
		.dest(dest_bus),
		.stress_bit(ram_stress_bit),
		.rd_addr(dest_bus.addr[AW-1:0]),
		.rd_data(s_rd),
		.locked(stress_lock_state[1]),
		.test_in(ram_test_in[1])
	);

	// Control-block RAM with lock
	dpt_ram_cell #(.AW(AW)) u_scb (
		.core_clk(core_clk),
		.rst(rst),
		.sel(scb_wr),
		.dest(dest_bus),
		.stress_bit(ram_stress_bit),
		.rd_addr(dest_bus.addr[AW-1:0]),
		.rd_data(c_rd),
		.locked(stress_lock_state[2]),
		.test_in(ram_test_in[2])
	);

	assign stress_lock_state[0] = |q_lock;
	assign ram_test_in[0] = |q_tst;

	// Remember which RAM a read addressed
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_src_reg <= 2'b00;
		end else if (scratch_rd) begin
			rd_src_reg <= 2'b01;
		end else if (scb_rd) begin
			rd_src_reg <= 2'b10;
		end else if (data_rd) begin
			rd_src_reg <= 2'b00;
		end
	end

	// Flag a RAM read so its byte is loaded once and then held;
	// the lane is kept since the read pointer has moved on by then
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_pend_reg <= 1'b0;
			lane_reg <= 2'b00;
		end else begin
			rd_pend_reg <= scratch_rd || scb_rd || data_rd;
			lane_reg <= rptr_reg[1:0];
		end
	end

	// Source bus: pointer reads and RAM read-back
	always_ff @(posedge core_clk) begin
		if (rst) begin
			source_read_bus <= 8'h00;
		end else if (wptr_rd) begin
			source_read_bus <= {test_mode & stress_lock_state[0],
				test_mode & wptr_reg[6], wptr_reg[5:0]};
		end else if (rptr_rd) begin
			source_read_bus <= {test_mode & fifo_data_holding_flag,
				test_mode & rptr_reg[6], rptr_reg[5:0]};
		end else if (rd_pend_reg) begin
			case (rd_src_reg)
				2'b01: source_read_bus <= s_rd;
				2'b10: source_read_bus <= c_rd;
				default: source_read_bus <= q_rd[lane_reg];
			endcase
		end
	end
endmodule
`default_nettype wire

// [sim/dpt_test_sva.sv]
// Checker for dpt_test_top: lock entry, release and pointer-read bits.
// Sees only the top ports; bound into every dpt_test_top below.
`timescale 1ns/100ps
`default_nettype none
module dpt_test_sva (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ctl_wr,
	input wire logic data_wr,
	input wire logic wptr_rd,
	input wire logic rptr_rd,
	input wire logic scratch_wr,
	input wire logic scb_wr,
	input wire dpt_pkg::dpt_dest_s dest_bus,
	input wire logic fifo_data_holding_flag,
	input wire logic [7:0] source_read_bus,
	input wire logic ram_stress_bit,
	input wire logic [2:0] stress_lock_state,
	input wire logic [2:0] ram_test_in
);
	// ==========
	// Test mode as last written, since it has no port of its own
	logic test_reg;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			test_reg <= 1'b0;
		end else if (ctl_wr) begin
			test_reg <= dest_bus.data[dpt_pkg::DPT_CTL_TEST_POS];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Write strobe seen while stress mode is on
	sequence s_lock_wr(wr);
		ram_stress_bit && wr && !dest_bus.wen_n;
	endsequence
	chk_scratch_lock: assert property (s_lock_wr(scratch_wr) |=> stress_lock_state[1])
		else $error("scratch lock missing");
	chk_scb_lock: assert property (s_lock_wr(scb_wr) |=> stress_lock_state[2])
		else $error("scb lock missing");
	chk_fifo_lock: assert property (s_lock_wr(data_wr) |=> stress_lock_state[0])
		else $error("fifo lock missing");
	chk_test_input: assert property (ram_test_in == stress_lock_state)
		else $error("test input differs from lock");
	chk_lock_free: assert property (
		$fell(ram_stress_bit) |-> ##[0:1] stress_lock_state == 3'h0
	) else $error("locks not released");
	chk_lock_hold: assert property (
		stress_lock_state[1] && ram_stress_bit && !ctl_wr |=> stress_lock_state[1]
	) else $error("lock dropped early");
	chk_plain_ptr: assert property (
		(wptr_rd || rptr_rd) && !test_reg |=> source_read_bus[7:6] == 2'h0
	) else $error("status bits seen outside test");
	chk_wptr_lock: assert property (
		wptr_rd && test_reg |=> source_read_bus[7] == $past(stress_lock_state[0])
	) else $error("write pointer lock bit wrong");
	chk_rptr_hold: assert property (
		rptr_rd && test_reg |=> source_read_bus[7] == $past(fifo_data_holding_flag)
	) else $error("read pointer holding bit wrong");
endmodule
bind dpt_test_top dpt_test_sva u_dpt_test_sva (.core_clk, .rst, .ctl_wr, .data_wr, .wptr_rd, .rptr_rd,
	.scratch_wr, .scb_wr, .dest_bus, .fifo_data_holding_flag, .source_read_bus,
	.ram_stress_bit, .stress_lock_state, .ram_test_in);
`default_nettype wire

// [sim/dpt_hold_model.sv]
// Model of the FIFO data path side: presents the data-holding status level.
// Assumes the bench loads a new level with a strobe held for two cycles.
`timescale 1ns/100ps
`default_nettype none
module dpt_hold_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hold_ld, // Take a new level
	input wire logic hold_lv, // Level to present
	output logic fifo_data_holding_flag // Holding status
);
	// ==========
	// Status level changes only when loaded
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fifo_data_holding_flag <= 1'b0;
		end else if (hold_ld) begin
			fifo_data_holding_flag <= hold_lv;
		end
	end
endmodule
`default_nettype wire

// [sim/fifo_and_dual_port_ram_test_tb.sv]
// Bench for the dual-port RAM test logic: pointer reads and stress locks.
// Assumes the checker binds itself into the design top.
`timescale 1ns/100ps
`default_nettype none
module fifo_and_dual_port_ram_test_tb;
	// ==========
	// Stimulus, observation and scoreboard
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [10:0] stb; // Access strobes in port order
	dpt_pkg::dpt_dest_s dest_bus;
	logic hold_ld, hold_lv, fifo_data_holding_flag, quad, stress;
	logic p1 = 1'b0;
	logic [2:0] pr = 3'h0;
	logic [2:0] lock;
	logic [7:0] v [0:3]; // Bytes quad-written to the FIFO
	logic [7:0] srb, a, d, exp_q[$];
	int fails = 0, checks = 0, cyc = 0, seed;
	always #4 core_clk = ~core_clk;
	dpt_hold_model u_dpt_hold_model (.core_clk, .rst, .hold_ld, .hold_lv, .fifo_data_holding_flag);
	dpt_test_top u_dpt_test_top (.core_clk, .rst, .ctl_wr(stb[0]), .data_wr(stb[1]),
		.wptr_wr(stb[2]), .rptr_wr(stb[3]), .data_rd(stb[4]), .wptr_rd(stb[5]), .rptr_rd(stb[6]),
		.scratch_wr(stb[7]), .scratch_rd(stb[8]), .scb_wr(stb[9]), .scb_rd(stb[10]),
		.dest_bus, .fifo_data_holding_flag, .source_read_bus(srb), .quad_write_test_bit(quad),
		.ram_stress_bit(stress), .stress_lock_state(lock), .ram_test_in());
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		checks++;
		if (got !== e) begin
			fails++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, e);
		end
	endtask
	// One access: strobe for one edge, then an idle edge
	task automatic acc(input int k, input logic [7:0] ad, input logic [7:0] dt, input logic w = 1'b0);
		stb[k] <= 1'b1;
		dest_bus <= '{w, ad, dt};
		@(posedge core_clk);
		stb <= 11'h000;
		dest_bus.wen_n <= 1'b1;
		@(posedge core_clk);
	endtask
	// Read: note the expected byte, the watcher compares it
	task automatic rd(input int k, input logic [7:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		acc(k, ad, 8'h00, 1'b1);
		repeat (2) @(posedge core_clk);
	endtask
	// Mode bits and locks, as {quad, stress, locks}
	task automatic lk(input logic [4:0] e);
		@(negedge core_clk);
		chk({3'h0, quad, stress, lock}, {3'h0, e});
		@(posedge core_clk);
	endtask
	task automatic give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watcher: pointer reads land after 1 edge, RAM reads within 3
	always @(posedge core_clk) begin
		p1 <= stb[5] | stb[6];
		pr <= {pr[1:0], stb[4] | stb[8] | stb[10]};
		cyc <= cyc + 1;
		if (p1 || pr[2]) begin
			chk(srb, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
		end
		if (cyc == 2000) begin
			fails++;
			give_verdict;
		end
	end
	initial begin
		seed = 32'hAC4FCA26;
		stb = 11'h000;
		dest_bus = '{1'b1, 8'h00, 8'h00};
		{hold_ld, hold_lv} = 2'h0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		acc(0, 8'h00, 8'h05);
		lk(5'h10);
		acc(2, 8'h00, 8'h3C);
		// Four quad writes fill groups 3C..3F and wrap the pointer
		for (int k = 0; k < 4; k++) begin
			v[k] = 8'($random(seed));
			acc(1, 8'h00, v[k]);
		end
		rd(5, 8'h00, 8'h40);
		acc(1, 8'h00, 8'($random(seed)));
		rd(5, 8'h00, 8'h41);
		// Byte p is read from lane p[1:0], so these reads visit all four lanes
		acc(3, 8'h00, 8'h3C);
		for (int k = 0; k < 4; k++) begin
			rd(4, 8'h00, v[k]);
		end
		rd(6, 8'h00, 8'h40);
		hold_lv <= 1'($random(seed));
		hold_ld <= 1'b1;
		acc(3, 8'h00, 8'h25);
		hold_ld <= 1'b0;
		rd(6, 8'h00, {hold_lv, 7'h25});
		acc(0, 8'h00, 8'h00);
		rd(5, 8'h00, 8'h01);
		rd(6, 8'h00, 8'h25);
		acc(0, 8'h00, 8'h04);
		a = 8'($random(seed)) & 8'h3F;
		d = 8'($random(seed));
		acc(7, a, d);
		acc(9, a, ~d);
		acc(0, 8'h00, 8'h06);
		acc(7, a, d);
		acc(9, a, ~d);
		acc(1, 8'h00, d);
		lk(5'h0F);
		rd(5, 8'h00, 8'hC2);
		acc(7, a, ~d);
		acc(9, a, d);
		repeat (dpt_pkg::DPT_STRESS_CYC) @(posedge core_clk);
		rd(8, a, d);
		rd(10, a, ~d);
		acc(0, 8'h00, 8'h04);
		lk(5'h00);
		acc(7, a, ~d);
		rd(8, a, ~d);
		give_verdict;
	end
endmodule
`default_nettype wire
